// ===== rtl/sld_pkg.sv
// constants and types of the packet-engine control block
package sld_pkg;
	// register byte offsets
	localparam logic [11:0] SLD_OFF_CONF   = 12'h000;
	localparam logic [11:0] SLD_OFF_RAW    = 12'h004;
	localparam logic [11:0] SLD_OFF_STATUS = 12'h008;
	localparam logic [11:0] SLD_OFF_ENA    = 12'h00C;
	localparam logic [11:0] SLD_OFF_CLR    = 12'h010;
	localparam logic [11:0] SLD_OFF_SLINK  = 12'h03C;
	localparam logic [11:0] SLD_OFF_RLINK  = 12'h040;
	localparam logic [11:0] SLD_OFF_VEC    = 12'h04C;
	localparam logic [11:0] SLD_OFF_TOKEN  = 12'h054;
	localparam logic [11:0] SLD_OFF_LENUPD = 12'h060;
	localparam logic [11:0] SLD_OFF_LENVAL = 12'h064;

	// event vector layout: doorbells low, engine events above
	localparam int SLD_NUM_EV  = 18;
	localparam int SLD_NUM_DB  = 8;
	localparam int SLD_NUM_HW  = 10;
	localparam int SLD_DB_LSB  = 0;
	localparam int SLD_HW_LSB  = 8;

	// configuration bits
	localparam int SLD_CONF_SEND_RST = 0;
	localparam int SLD_CONF_RECV_RST = 1;
	localparam int SLD_CONF_SST_LSB  = 4;
	localparam int SLD_CONF_RST_LSB  = 6;

	// chain control fields
	localparam int SLD_ADDR_W      = 20;
	localparam int SLD_LINK_HALT   = 28;
	localparam int SLD_LINK_GO     = 29;
	localparam int SLD_LINK_RESUME = 30;

	// counters
	localparam int SLD_TOK_W       = 12;
	localparam int SLD_TOK_ADD     = 12;
	localparam int SLD_TOK_CNT_LSB = 16;
	localparam int SLD_LEN_W       = 20;
	localparam int SLD_LEN_ADD     = 20;
	localparam int SLD_VEC_W       = 8;

	localparam logic [31:0] SLD_RESET_WORD = 32'h0000_0000;

	typedef enum logic [1:0] {
		SLD_CH_IDLE = 2'b00,
		SLD_CH_RUN  = 2'b01,
		SLD_CH_HALT = 2'b11
	} sld_chain_e;
endpackage : sld_pkg

// ===== rtl/sld_top.sv
// control, event and counter logic of the slave linked-list packet engine
//
// Summary of operation
// - separate enables for send-chain and receive-chain descriptor errors.
// - enables for send done, receive done, buffer sent, buffer filled.
// - enables for receive overflow and send underflow.
// - enables for receive-init and send-init events.
// - eight independent enables for host doorbells 0 to 7.
// - write-only clear bit per source; writing one clears pending flag.
// - send go starts send chain at send first address.
// - send first address is 20 bits, readable and writable.
// - resume continues a chain from its current pointer.
// - halt stops a chain.
// - receive go starts receive chain at receive first address.
// - receive first address is 20 bits, readable and writable.
// - write-only vector raises interrupts toward the host.
// - read-only accumulated receive buffer count.
// - add bit adds written delta to receive buffer count.
// - add bit accumulates written length into sent length count.
// - read-only sent length value.
// - software bits reset send and receive state machines.
// - host side sees the accumulated receive buffer count.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sld_top
	import sld_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    link_clk,
	input  wire logic [SLD_NUM_DB-1:0]   host_doorbell,
	input  wire logic [SLD_NUM_HW-1:0]   hw_event,
	input  wire logic                    send_next_valid,
	input  wire logic [SLD_ADDR_W-1:0]   send_next_addr,
	input  wire logic                    receive_next_valid,
	input  wire logic [SLD_ADDR_W-1:0]   receive_next_addr,
	output logic                         send_chain_start,
	output logic                         send_chain_active,
	output logic      [SLD_ADDR_W-1:0]   send_chain_addr,
	output logic                         receive_chain_start,
	output logic                         receive_chain_active,
	output logic      [SLD_ADDR_W-1:0]   receive_chain_addr,
	output logic      [SLD_VEC_W-1:0]    to_host_vector,
	output logic      [SLD_TOK_W-1:0]    host_view_rx_buffer_count,
	output logic                         event_irq
);

	typedef struct packed {
		logic [SLD_NUM_EV-1:0]            ena;
		logic [SLD_NUM_EV-1:0]            raw;
		logic [1:0]                       conf;
		sld_chain_e [1:0]                 ch_st;
		logic [1:0][SLD_ADDR_W-1:0]       first;
		logic [1:0][SLD_ADDR_W-1:0]       ptr;
		logic [1:0]                       start;
		logic [SLD_TOK_W-1:0]             token;
		logic [SLD_LEN_W-1:0]             len;
		logic [SLD_VEC_W-1:0]             vec;
		logic [31:0]                      rdata;
		logic                             slverr;
		logic                             lclk_m;
		logic                             lclk_q;
		logic                             lclk_d;
		logic [SLD_NUM_DB-1:0]            db_m;
		logic [SLD_NUM_DB-1:0]            db_q;
		logic [SLD_NUM_DB-1:0]            db_cap;
	} sld_state_s;

	sld_state_s                 st;
	sld_state_s                 next_st;
	logic                       wr_acc;
	logic                       setup;
	logic                       link_rise;
	logic [SLD_NUM_EV-1:0]      ev;
	logic [SLD_NUM_EV-1:0]      clr;
	logic [SLD_NUM_EV-1:0]      masked;
	logic [1:0]                 ch_rst;
	logic [1:0][31:0]           link_wr;
	logic [1:0]                 next_valid;
	logic [1:0][SLD_ADDR_W-1:0] next_addr;

	// no wait states: read data is captured in the setup cycle
	assign pready  = psel & penable;
	assign pslverr = pready & st.slverr;
	assign setup   = psel & ~penable;
	assign wr_acc  = psel & penable & pwrite;
	assign masked  = st.raw & st.ena;
	assign next_valid = {receive_next_valid, send_next_valid};
	assign next_addr  = {receive_next_addr, send_next_addr};

	always_comb begin
		next_st   = st;
		link_rise = st.lclk_q & ~st.lclk_d;
		ev        = '0;
		clr       = '0;
		ch_rst    = '0;
		link_wr   = '0;

		// link clock and doorbells: first stage feeds only the second
		next_st.lclk_m = link_clk;
		next_st.lclk_q = st.lclk_m;
		// third stage only finds edges; a rise shows for one cycle
		next_st.lclk_d = st.lclk_q;
		next_st.db_m   = host_doorbell;
		next_st.db_q   = st.db_m;
		if (link_rise) begin
			next_st.db_cap = st.db_q;
		end

		if (link_rise) begin
			ev[SLD_DB_LSB +: SLD_NUM_DB] = st.db_q & ~st.db_cap;
		end
		// engine pulses already run on clk_sys, so no synchroniser
		ev[SLD_HW_LSB +: SLD_NUM_HW] = hw_event;

		// clear pulse; set wins over clear
		if (wr_acc && paddr == SLD_OFF_CLR) begin
			clr = pwdata[SLD_NUM_EV-1:0];
		end
		next_st.raw = (st.raw & ~clr) | ev;

		if (wr_acc && paddr == SLD_OFF_ENA) begin
			next_st.ena = pwdata[SLD_NUM_EV-1:0];
		end
		if (wr_acc && paddr == SLD_OFF_CONF) begin
			next_st.conf = pwdata[SLD_CONF_RECV_RST:SLD_CONF_SEND_RST];
		end
		ch_rst = next_st.conf;

		if (wr_acc && paddr == SLD_OFF_SLINK) begin
			link_wr[0] = pwdata;
		end
		if (wr_acc && paddr == SLD_OFF_RLINK) begin
			link_wr[1] = pwdata;
		end

		// per-chain control; reset beats halt beats go beats resume
		next_st.start = '0;
		for (int c = 0; c < 2; c++) begin
			// first address follows every write, action bits or not
			// first address store
			if (wr_acc && paddr == (c == 0 ? SLD_OFF_SLINK : SLD_OFF_RLINK)) begin
				next_st.first[c] = pwdata[SLD_ADDR_W-1:0];
			end
			if (st.ch_st[c] == SLD_CH_RUN && next_valid[c]) begin
				next_st.ptr[c] = next_addr[c];
			end
			if (ch_rst[c]) begin
				next_st.ch_st[c] = SLD_CH_IDLE;
			end else if (link_wr[c][SLD_LINK_HALT]) begin
				next_st.ch_st[c] = SLD_CH_HALT;
			end else if (link_wr[c][SLD_LINK_GO]) begin
				next_st.ch_st[c] = SLD_CH_RUN;
				next_st.ptr[c]   = pwdata[SLD_ADDR_W-1:0];
				next_st.start[c] = 1'b1;
			end else if (link_wr[c][SLD_LINK_RESUME]) begin
				next_st.ch_st[c] = SLD_CH_RUN;
			end
		end

		// vector pulse, one cycle per write
		next_st.vec = '0;
		if (wr_acc && paddr == SLD_OFF_VEC) begin
			next_st.vec = pwdata[SLD_VEC_W-1:0];
		end

		if (wr_acc && paddr == SLD_OFF_TOKEN && pwdata[SLD_TOK_ADD]) begin
			next_st.token = st.token + pwdata[SLD_TOK_W-1:0];
		end
		if (wr_acc && paddr == SLD_OFF_LENUPD && pwdata[SLD_LEN_ADD]) begin
			next_st.len = st.len + pwdata[SLD_LEN_W-1:0];
		end

		// read path; action bits and write-only fields read zero
		if (setup) begin
			next_st.rdata  = SLD_RESET_WORD;
			next_st.slverr = 1'b0;
			unique case (paddr)
				SLD_OFF_CONF: begin
					next_st.rdata[SLD_CONF_RECV_RST:SLD_CONF_SEND_RST] = st.conf;
					next_st.rdata[SLD_CONF_SST_LSB +: 2] = st.ch_st[0];
					next_st.rdata[SLD_CONF_RST_LSB +: 2] = st.ch_st[1];
				end
				SLD_OFF_RAW: begin
					next_st.rdata[SLD_NUM_EV-1:0] = st.raw;
				end
				SLD_OFF_STATUS: begin
					next_st.rdata[SLD_NUM_EV-1:0] = masked;
				end
				SLD_OFF_ENA: begin
					next_st.rdata[SLD_NUM_EV-1:0] = st.ena;
				end
				SLD_OFF_SLINK: begin
					next_st.rdata[SLD_ADDR_W-1:0] = st.first[0];
				end
				SLD_OFF_RLINK: begin
					next_st.rdata[SLD_ADDR_W-1:0] = st.first[1];
				end
				SLD_OFF_TOKEN: begin
					next_st.rdata[SLD_TOK_CNT_LSB +: SLD_TOK_W] = st.token;
				end
				SLD_OFF_LENVAL: begin
					next_st.rdata[SLD_LEN_W-1:0] = st.len;
				end
				SLD_OFF_CLR, SLD_OFF_VEC, SLD_OFF_LENUPD: begin
					next_st.rdata = SLD_RESET_WORD;
				end
				default: begin
					next_st.slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// every field to zero, so both chains fall back to idle
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata                    = st.rdata;
	assign send_chain_start          = st.start[0];
	assign receive_chain_start       = st.start[1];
	assign send_chain_active         = (st.ch_st[0] == SLD_CH_RUN);
	assign receive_chain_active      = (st.ch_st[1] == SLD_CH_RUN);
	assign send_chain_addr           = st.ptr[0];
	assign receive_chain_addr        = st.ptr[1];
	assign to_host_vector            = st.vec;
	assign host_view_rx_buffer_count = st.token;
	assign event_irq                 = |masked;

	// a write is seen at its access edge; reset masks every property
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_wr(logic [11:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence

	sequence s_one_pulse(logic sig);
		sig ##1 !sig;
	endsequence

	AST_CLR_EFFECT: assert property (
		s_wr(SLD_OFF_CLR) ##0 (pwdata[0] && !ev[0]) |=> !st.raw[0])
		else $error("clear write left pending flag set");

	AST_SET_WINS: assert property (
		ev[0] |=> st.raw[0])
		else $error("event lost against clear");

	AST_IRQ_MASKED: assert property (
		s_wr(SLD_OFF_ENA) ##0 (pwdata == 32'h0000_0000) |=> !event_irq)
		else $error("interrupt active with all enables off");

	AST_TOKEN_ADD: assert property (
		s_wr(SLD_OFF_TOKEN) ##0 pwdata[SLD_TOK_ADD] |=>
		st.token == SLD_TOK_W'($past(st.token) + $past(pwdata[SLD_TOK_W-1:0])))
		else $error("token count did not add delta");

	AST_TOKEN_NOP: assert property (
		s_wr(SLD_OFF_TOKEN) ##0 !pwdata[SLD_TOK_ADD] |=> $stable(st.token))
		else $error("token count moved without add bit");

	AST_LEN_ADD: assert property (
		s_wr(SLD_OFF_LENUPD) ##0 pwdata[SLD_LEN_ADD] |=>
		st.len == SLD_LEN_W'($past(st.len) + $past(pwdata[SLD_LEN_W-1:0])))
		else $error("sent length did not accumulate");

	AST_SEND_GO: assert property (
		s_wr(SLD_OFF_SLINK) ##0 (pwdata[SLD_LINK_GO] && !pwdata[SLD_LINK_HALT]
		&& !st.conf[SLD_CONF_SEND_RST]) |=> send_chain_active
		&& send_chain_addr == $past(pwdata[SLD_ADDR_W-1:0]) ##0 s_one_pulse(send_chain_start))
		else $error("send go did not start at first address");

	AST_RECV_HALT: assert property (
		s_wr(SLD_OFF_RLINK) ##0 (pwdata[SLD_LINK_HALT] && !st.conf[SLD_CONF_RECV_RST])
		|=> !receive_chain_active [*2])
		else $error("receive chain did not halt");

	AST_RESUME_PTR: assert property (
		s_wr(SLD_OFF_RLINK) ##0 (pwdata[SLD_LINK_RESUME] && !pwdata[SLD_LINK_GO]
		&& !pwdata[SLD_LINK_HALT] && !st.conf[SLD_CONF_RECV_RST] && !receive_next_valid)
		|=> receive_chain_active && $stable(receive_chain_addr))
		else $error("resume moved the pointer or did not run");

	AST_FSM_RESET: assert property (
		st.conf[SLD_CONF_SEND_RST] |=> !send_chain_active)
		else $error("send state machine ran while held in reset");

	AST_VEC_PULSE: assert property (
		s_wr(SLD_OFF_VEC) |=> to_host_vector == $past(pwdata[SLD_VEC_W-1:0])
		##1 to_host_vector == '0)
		else $error("vector not a single-cycle pulse");

	AST_RECV_GO: assert property (
		s_wr(SLD_OFF_RLINK) ##0 (pwdata[SLD_LINK_GO] && !pwdata[SLD_LINK_HALT]
		&& !st.conf[SLD_CONF_RECV_RST]) |=> receive_chain_active
		&& receive_chain_addr == $past(pwdata[SLD_ADDR_W-1:0]) ##0 s_one_pulse(receive_chain_start))
		else $error("receive go did not start at first address");

	AST_SEND_HALT: assert property (
		s_wr(SLD_OFF_SLINK) ##0 (pwdata[SLD_LINK_HALT] && !st.conf[SLD_CONF_SEND_RST]
		&& !send_next_valid) |=> !send_chain_active && $stable(send_chain_addr))
		else $error("send chain did not halt in place");

	AST_SEND_RESUME: assert property (
		s_wr(SLD_OFF_SLINK) ##0 (pwdata[SLD_LINK_RESUME] && !pwdata[SLD_LINK_GO]
		&& !pwdata[SLD_LINK_HALT] && !st.conf[SLD_CONF_SEND_RST] && !send_next_valid)
		|=> send_chain_active && $stable(send_chain_addr))
		else $error("send resume moved the pointer or did not run");

	AST_RECV_FSM_RESET: assert property (
		st.conf[SLD_CONF_RECV_RST] |=> !receive_chain_active)
		else $error("receive state machine ran while held in reset");

	AST_ENA_WRITE: assert property (
		s_wr(SLD_OFF_ENA) |=> st.ena == $past(pwdata[SLD_NUM_EV-1:0]))
		else $error("enable bits not taken from the write");

	AST_LEN_NOP: assert property (
		s_wr(SLD_OFF_LENUPD) ##0 !pwdata[SLD_LEN_ADD] |=> $stable(st.len))
		else $error("sent length moved without add bit");

	AST_CLR_ZERO: assert property (
		s_wr(SLD_OFF_CLR) ##0 (pwdata[SLD_NUM_EV-1:0] == '0)
		|=> st.raw == ($past(st.raw) | $past(ev)))
		else $error("zero clear write dropped a pending flag");

	AST_START_RUN: assert property (
		send_chain_start |-> send_chain_active)
		else $error("send start pulse outside run state");

	AST_PTR_IDLE: assert property (
		!send_chain_active && !(wr_acc && paddr == SLD_OFF_SLINK)
		|=> $stable(send_chain_addr))
		else $error("send pointer moved while the chain was not running");

	AST_VEC_QUIET: assert property (
		!(wr_acc && paddr == SLD_OFF_VEC) |=> to_host_vector == '0)
		else $error("vector raised without a write");

	AST_RDATA_HOLD: assert property (
		!setup |=> $stable(prdata))
		else $error("read data changed outside a setup cycle");

	AST_DB_EDGE: assert property (
		link_rise && st.db_q[1] && !st.db_cap[1] |=> st.raw[1])
		else $error("doorbell edge not latched");

	AST_IRQ_RAISE: assert property (
		s_wr(SLD_OFF_ENA) ##0 ((pwdata[SLD_NUM_EV-1:0] & st.raw) != '0) |=> event_irq)
		else $error("enabled pending flag did not raise the interrupt");

endmodule : sld_top
`default_nettype wire

// ===== test/sld_host_model.sv
// behavioural host side: link clock bursts and doorbell levels
`timescale 1ns/1ps
`default_nettype none
module sld_host_model (
	input  wire logic       go,
	input  wire logic [7:0] ring,
	output logic            link_clk,
	output logic [7:0]      host_doorbell
);
	initial begin
		link_clk = 1'b0;
		host_doorbell = 8'h00;
	end
	// clock stands low between frames, so edges come only with traffic
	always @(posedge go) begin
		#7 host_doorbell = ring;
		repeat (3) begin
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
		host_doorbell = 8'h00;
	end
endmodule : sld_host_model
`default_nettype wire

// ===== test/sld_top_bench.sv
// self-checking bench of the packet-engine control block
`timescale 1ns/1ps
`default_nettype none
module sld_top_bench
	import sld_pkg::*;
;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} sld_row_s;
	sld_row_s    rows [24];
	logic        clk_sys, rst, psel, penable, pwrite, go, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [9:0]  hw_event;
	logic [1:0]  nv;
	logic [19:0] na;
	logic [7:0]  ring;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, link_clk, s_go, s_act, r_go, r_act, irq;
	wire logic [19:0] s_adr, r_adr;
	wire logic [7:0]  db, vec;
	wire logic [11:0] hv_cnt;
	wire logic [21:0] obs [2];
	int          error_cnt, tests_run, n;
	assign obs[0] = {s_go, s_act, s_adr};
	assign obs[1] = {r_go, r_act, r_adr};
	sld_host_model sld_host_model_inst (.go(go), .ring(ring), .link_clk(link_clk),
		.host_doorbell(db));
	sld_top sld_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clk(link_clk), .host_doorbell(db), .hw_event(hw_event),
		.send_next_valid(nv[0]), .send_next_addr(na), .receive_next_valid(nv[1]),
		.receive_next_addr(na), .send_chain_start(s_go), .send_chain_active(s_act),
		.send_chain_addr(s_adr), .receive_chain_start(r_go), .receive_chain_active(r_act),
		.receive_chain_addr(r_adr), .to_host_vector(vec), .host_view_rx_buffer_count(hv_cnt),
		.event_irq(irq));
	always #10 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	// one apb transfer; holds everything until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chain(input int c, input logic [11:0] a);
		// go loads the first address and pulses start once
		apb(1'b1, a, 32'h2001_2345);
		@(negedge clk_sys);
		chk(32'(obs[c]), {10'h0, 2'b11, 20'h12345}, "go");
		@(negedge clk_sys);
		chk(32'(obs[c]), {10'h0, 2'b01, 20'h12345}, "start pulse");
		@(posedge clk_sys);
		nv[c] <= 1'b1;
		na <= 20'h5A5A5;
		@(posedge clk_sys);
		nv <= 2'b00;
		apb(1'b1, a, 32'h1001_2345);
		@(negedge clk_sys);
		chk(32'(obs[c]), {10'h0, 2'b00, 20'h5A5A5}, "halt");
		@(posedge clk_sys);
		nv[c] <= 1'b1;
		na <= 20'h00111;
		@(posedge clk_sys);
		nv <= 2'b00;
		apb(1'b1, a, 32'h4001_2345);
		@(negedge clk_sys);
		chk(32'(obs[c][20:0]), {11'h0, 1'b1, 20'h5A5A5}, "resume");
		apb(1'b0, a, 32'h0);
		chk(q, 32'h0001_2345, "chain readback");
		apb(1'b1, SLD_OFF_CONF, 32'(c + 1));
		@(negedge clk_sys);
		chk({31'h0, obs[c][20]}, 32'h0, "fsm reset");
		apb(1'b1, SLD_OFF_CONF, 32'h0);
		$display("test chain %0d done", c);
	endtask : chain
	initial begin
		// about ten thousand cycles, several times the expected run
		#200_000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end
	initial begin
		{clk_sys, rst, psel, penable, pwrite, go, paddr, pwdata} = {6'b010000, 44'h0};
		{hw_event, nv, na, ring} = 40'h0;
		rows = '{'{1'b0, 12'h00C, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h03C, 32'h0, 32'h0, 1'b0},
			'{1'b0, 12'h040, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h054, 32'h0, 32'h0, 1'b0},
			'{1'b0, 12'h064, 32'h0, 32'h0, 1'b0}, '{1'b1, 12'h00C, 32'h3FFFF, 32'h0, 1'b0},
			'{1'b0, 12'h00C, 32'h0, 32'h3FFFF, 1'b0}, '{1'b1, 12'h00C, 32'h0, 32'h0, 1'b0},
			'{1'b1, 12'h03C, 32'h100A_BCDE, 32'h0, 1'b0}, '{1'b0, 12'h03C, 32'h0, 32'hABCDE, 1'b0},
			'{1'b1, 12'h040, 32'hFFFFF, 32'h0, 1'b0}, '{1'b0, 12'h040, 32'h0, 32'hFFFFF, 1'b0},
			'{1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'hFFC, 32'h1, 32'h0, 1'b1},
			'{1'b1, 12'h054, 32'h1005, 32'h0, 1'b0}, '{1'b1, 12'h054, 32'h0003, 32'h0, 1'b0},
			'{1'b1, 12'h054, 32'h1003, 32'h0, 1'b0}, '{1'b0, 12'h054, 32'h0, 32'h80000, 1'b0},
			'{1'b1, 12'h060, 32'h100010, 32'h0, 1'b0}, '{1'b1, 12'h060, 32'h20, 32'h0, 1'b0},
			'{1'b1, 12'h060, 32'h100020, 32'h0, 1'b0}, '{1'b0, 12'h064, 32'h0, 32'h30, 1'b0},
			'{1'b1, 12'h064, 32'hFFFFF, 32'h0, 1'b0}, '{1'b0, 12'h064, 32'h0, 32'h30, 1'b0}};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(negedge clk_sys);
		chk({hv_cnt, vec, s_act, r_act, irq}, 32'h0, "reset outputs");
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].q, "row data");
			chk({31'h0, e}, {31'h0, rows[i].e}, "row error");
		end
		chk({20'h0, hv_cnt}, 32'h8, "host view count");
		$display("test register rows done");
		for (int k = 0; k < SLD_NUM_EV; k++) begin
			apb(1'b1, SLD_OFF_ENA, 32'h1 << k);
			@(posedge clk_sys);
			if (k < SLD_NUM_DB) {ring, go} <= {8'h1 << k, 1'b1};
			else hw_event <= 10'h1 << (k - SLD_HW_LSB);
			@(posedge clk_sys);
			{go, hw_event} <= 11'h0;
			for (n = 0; irq !== 1'b1 && n < 100; n++) @(negedge clk_sys);
			chk({31'h0, irq}, 32'h1, "enabled event");
			apb(1'b1, SLD_OFF_CLR, 32'h0);
			apb(1'b0, SLD_OFF_STATUS, 32'h0);
			chk(q, 32'h1 << k, "zero clear");
			apb(1'b1, SLD_OFF_CLR, 32'h1 << k);
			apb(1'b0, SLD_OFF_RAW, 32'h0);
			chk({q[31:1], irq}, 32'h0, "cleared");
			// a host frame lasts about 25 cycles; the next ring must not land inside it
			if (k < SLD_NUM_DB) repeat (20) @(posedge clk_sys);
		end
		apb(1'b1, SLD_OFF_ENA, 32'h0);
		@(posedge clk_sys);
		hw_event <= 10'h200;
		@(posedge clk_sys);
		hw_event <= 10'h0;
		apb(1'b0, SLD_OFF_STATUS, 32'h0);
		chk({q[31:1], irq}, 32'h0, "masked event");
		apb(1'b0, SLD_OFF_RAW, 32'h0);
		chk(q, 32'h2_0000, "raw under mask");
		$display("test events done");
		chain(0, SLD_OFF_SLINK);
		chain(1, SLD_OFF_RLINK);
		apb(1'b1, SLD_OFF_VEC, 32'hA5);
		@(negedge clk_sys);
		chk({24'h0, vec}, 32'hA5, "vector");
		@(negedge clk_sys);
		chk({24'h0, vec}, 32'h0, "vector pulse");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		apb(1'b0, SLD_OFF_TOKEN, 32'h0);
		chk({q[31:1], irq}, 32'h0, "mid-run reset");
		$display("test vector and reset done");
		close_out();
	end
endmodule : sld_top_bench
`default_nettype wire
